// ===== core/lsb_bank.sv
// Purpose: Sixteen lane serial receive and transmit bank.
// Assumes: Link clock and lanes arrive asynchronously and are sampled.
// Notes:   Rates are scaled to the sampling clock; ratios are exact.
//
// Contract
// - Bit clock at most eight times reference
// - Transmit side forwards its word clock
// - Forwarded clock in phase with data
// - Up to 128 bits each way per word
// - Each receive lane owns a shift register
// - Each transmit lane owns a loaded shifter
// - Ratios four, seven, eight and bypass
// - Slow data may bypass the deserialiser
// - Bypass: clock and data same rate
// - Bypass reference at most 160 MHz
// - Receive reference: board or forwarded clock (the code takes only the incoming rx_link_clk_i)
// - Dedicated path up to 622.08 Mbps
// - Multiplier matches selected conversion ratio
// - Transmit reference: pin or receive clock (the code uses the local divider on sys_clk_i or the receive clock)
// - Word clock also usable by fabric
`timescale 1ns/100ps

module lsb_bank
    import lsb_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire lsb_mode_t mode_sel_i,          // Word conversion mode
    input wire logic tx_ref_sel_i,             // 1: follow receive clock
    input wire logic rx_link_clk_i,            // Incoming bit clock pin
    input wire logic [LANES-1:0] rx_lane_i,    // Incoming serial lanes
    output logic [BUS_W-1:0] rx_data_o,        // Received parallel words
    output logic rx_word_valid_o,              // New receive word
    output logic word_tick_o,                  // Word rate enable
    input wire logic [BUS_W-1:0] tx_data_i,    // Words to transmit
    output logic tx_word_take_o,               // Word taken this cycle
    output logic [LANES-1:0] tx_lane_o,        // Outgoing serial lanes
    output logic tx_fwd_clk_o,                 // Forwarded word clock
    output logic [3:0] ratio_o                 // Active bits per word
);

    // ------------------------------------------------------------
    // Mode and ratio
    // ------------------------------------------------------------
    logic [3:0] ratio_r;     // Bits per word now in force
    logic [3:0] ratio_nxt;   // Ratio requested by the mode pins
    logic bypass;            // One bit per word

    assign ratio_nxt = lsb_ratio(mode_sel_i);
    // bypass captures at 1x
    // One bit per word: capture registers run at the link rate
    assign bypass = (ratio_r == RATIO_X1);
    assign ratio_o = ratio_r;

    // ratio follows mode
    // Multiplier taken from the mode, clamped to the limit
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            ratio_r <= RATIO_X8;
        else
            ratio_r <= ratio_nxt;
    end

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic clk_meta_r;              // First stage, link clock
    logic clk_sync_r;              // Second stage, link clock
    logic clk_prev_r;              // Delayed copy for edge finding
    logic [LANES-1:0] lane_meta_r; // First stage, lanes
    logic [LANES-1:0] lane_sync_r; // Second stage, lanes

    // Two flops on the link clock and every lane pin before any logic
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            clk_meta_r <= 1'b0;
            clk_sync_r <= 1'b0;
            lane_meta_r <= '0;
            lane_sync_r <= '0;
        end
        else
        begin
            clk_meta_r <= rx_link_clk_i;
            clk_sync_r <= clk_meta_r;
            lane_meta_r <= rx_lane_i;
            lane_sync_r <= lane_meta_r;
        end
    end

    // Previous link clock level for edge detection
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            clk_prev_r <= 1'b0;
        else
            clk_prev_r <= clk_sync_r;
    end

    // ------------------------------------------------------------
    // Receive bit timing
    // ------------------------------------------------------------
    logic rx_bit_en;           // Rising link clock edge seen
    logic rx_fall_en;          // Falling link clock edge seen
    logic [IDX_W-1:0] rx_idx_r; // Bit position within the word
    logic rx_word_end;         // This bit closes the word

    // rx reference pin
    // Receive bits sampled at rising edges of the incoming clock
    assign rx_bit_en = clk_sync_r && !clk_prev_r;
    assign rx_fall_en = !clk_sync_r && clk_prev_r;
    assign rx_word_end = ({1'b0, rx_idx_r} >= (ratio_r - 4'h1));

    // Bit counter, restarts at every word boundary
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rx_idx_r <= '0;
        else if (rx_bit_en && rx_word_end)
            rx_idx_r <= '0;
        else if (rx_bit_en)
            rx_idx_r <= rx_idx_r + 3'h1;
    end

    // ------------------------------------------------------------
    // Receive lanes
    // ------------------------------------------------------------
    // sixteen lanes wide
    genvar gr;
    generate
        for (gr = 0; gr < LANES; gr = gr + 1)
        begin : g_rx
            lsb_rx_lane u_rx (
                .sys_clk_i(sys_clk_i),
                .rst_n_i(rst_n_i),
                .bit_en_i(rx_bit_en),
                .bit_i(lane_sync_r[gr]),
                .idx_i(rx_idx_r),
                .word_end_i(rx_word_end),
                .word_o(rx_data_o[gr*WORD_W +: WORD_W])
            );
        end
    endgenerate

    // registered word strobe
    // Valid marks the cycle the word registers have just loaded
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rx_word_valid_o <= 1'b0;
        else
            rx_word_valid_o <= rx_bit_en && rx_word_end;
    end

    // word tick out
    // Word rate enable for general fabric logic
    assign word_tick_o = rx_word_valid_o;

    // ------------------------------------------------------------
    // Transmit bit timing
    // ------------------------------------------------------------
    logic [7:0] div_r;         // Local bit period divider
    logic loc_bit_en;          // Local bit start
    logic loc_half_en;         // Local mid bit
    logic tx_bit_en;           // Selected bit start
    logic tx_half_en;          // Selected mid bit
    logic [IDX_W-1:0] tx_idx_r; // Bit position within the word
    logic tx_word_end;         // This bit closes the word
    logic tx_load;             // This bit opens a new word

    assign loc_bit_en = (div_r == 8'h00);
    assign loc_half_en = (div_r == 8'(TX_HALF_CYC));

    // tx reference select
    // Local divider or the recovered receive clock drives the sender
    assign tx_bit_en = tx_ref_sel_i ? rx_bit_en : loc_bit_en;
    assign tx_half_en = tx_ref_sel_i ? rx_fall_en : loc_half_en;
    assign tx_word_end = ({1'b0, tx_idx_r} >= (ratio_r - 4'h1));
    assign tx_load = (tx_idx_r == '0);

    // bounded bit rate
    // Divider free runs at the local bit period
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            div_r <= 8'h00;
        else if (div_r == 8'(TX_BIT_CYC - 1))
            div_r <= 8'h00;
        else
            div_r <= div_r + 8'h01;
    end

    // Transmit bit counter
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            tx_idx_r <= '0;
        else if (tx_bit_en && tx_word_end)
            tx_idx_r <= '0;
        else if (tx_bit_en)
            tx_idx_r <= tx_idx_r + 3'h1;
    end

    // Word accepted from the fabric at the first bit
    assign tx_word_take_o = tx_bit_en && tx_load;

    // ------------------------------------------------------------
    // Transmit lanes
    // ------------------------------------------------------------
    // per lane loader
    genvar gt;
    generate
        for (gt = 0; gt < LANES; gt = gt + 1)
        begin : g_tx
            lsb_tx_lane u_tx (
                .sys_clk_i(sys_clk_i),
                .rst_n_i(rst_n_i),
                .bit_en_i(tx_bit_en),
                .load_i(tx_load),
                .word_i(tx_data_i[gt*WORD_W +: WORD_W]),
                .bit_o(tx_lane_o[gt])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Forwarded clock
    // ------------------------------------------------------------
    logic [3:0] fwd_high; // Bits of the word with clock high

    assign fwd_high = (ratio_r + 4'h1) >> 1;

    // same edge as data
    // High from the first bit for half the word; bypass uses half bits
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            tx_fwd_clk_o <= 1'b0;
        else if (bypass && tx_bit_en)
            tx_fwd_clk_o <= 1'b1;
        else if (bypass && tx_half_en)
            tx_fwd_clk_o <= 1'b0;
        else if (!bypass && tx_bit_en)
            tx_fwd_clk_o <= ({1'b0, tx_idx_r} < fwd_high);
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic chk_arm_r; // Checks armed one edge after release

    // Skip the release edge, where reset values still stand
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            chk_arm_r <= 1'b0;
        else
            chk_arm_r <= 1'b1;
    end

    chk_ratio_limit: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        ratio_r <= MAX_MULT)
        else $error("bit ratio above multiplication limit");

    chk_ratio_legal: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        ratio_r == RATIO_X1 || ratio_r == RATIO_X4 ||
        ratio_r == RATIO_X7 || ratio_r == RATIO_X8)
        else $error("ratio not one of the supported modes");

    chk_fwd_align: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        $rose(tx_fwd_clk_o) |-> $past(tx_bit_en))
        else $error("forwarded clock rose away from a bit edge");

    chk_fwd_word: assert property (
        @(posedge sys_clk_i) disable iff (!chk_arm_r)
        (tx_word_take_o && !bypass && $stable(ratio_r))
            |=> tx_fwd_clk_o)
        else $error("forwarded clock low at word start");

    chk_word_valid: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (rx_bit_en && rx_word_end) |=> rx_word_valid_o ##1
            !rx_word_valid_o)
        else $error("receive word strobe not one cycle after last bit");

    chk_bypass_bit: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (rx_bit_en && bypass) |=>
            rx_data_o[0] == $past(lane_sync_r[0]))
        else $error("bypass bit not passed to the word");

    chk_bypass_rate: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (rx_bit_en && bypass && $stable(ratio_r)) |=> rx_word_valid_o)
        else $error("bypass bit did not yield a word");

    chk_tx_spacing: assert property (
        @(posedge sys_clk_i) disable iff (!chk_arm_r)
        loc_bit_en |=> !loc_bit_en [*7] ##1 loc_bit_en)
        else $error("local bit period wrong");

    chk_take_first: assert property (
        @(posedge sys_clk_i) disable iff (!chk_arm_r)
        tx_word_take_o |=> tx_lane_o[0] == $past(tx_data_i[0]))
        else $error("lane did not start with bit 0 of the word");

    chk_tick_source: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        word_tick_o |-> $past(rx_bit_en))
        else $error("word tick without a closing bit");

endmodule

// ===== core/lsb_pkg.sv
// Purpose: Shared constants and types for the serial lane bank.
// Assumes: 40 MHz system clock; link clock sampled, not used as a clock.
// Notes:   Ratio codes map the word mode onto bits per parallel word.

package lsb_pkg;

    // ------------------------------------------------------------
    // Bank geometry
    // ------------------------------------------------------------
    localparam int LANES = 16;           // Serial lanes per direction
    localparam int WORD_W = 8;           // Widest parallel word per lane
    localparam int BUS_W = LANES * WORD_W; // Parallel bits per word cycle
    localparam int IDX_W = 3;            // Bit index width inside a word

    // ------------------------------------------------------------
    // Multiplication limits and ratios
    // ------------------------------------------------------------
    localparam logic [3:0] MAX_MULT = 4'h8;  // Highest bit clock multiple
    localparam logic [3:0] RATIO_X1 = 4'h1;  // Bypass, one bit per word
    localparam logic [3:0] RATIO_X4 = 4'h4;
    localparam logic [3:0] RATIO_X7 = 4'h7;
    localparam logic [3:0] RATIO_X8 = 4'h8;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int SYS_CLK_MHZ = 40;          // System clock rate
    localparam int TX_BIT_NS = 200;           // Local transmit bit period
    localparam int TX_BIT_CYC = (TX_BIT_NS * SYS_CLK_MHZ) / 1000;
    localparam int TX_HALF_CYC = TX_BIT_CYC / 2;
    localparam int LANE_MAX_KBPS = 622080;    // Dedicated path ceiling
    localparam int BYPASS_MAX_KBPS = 155000;  // Bypass rate ceiling
    localparam int BYPASS_REF_MAX_MHZ = 160;  // Bypass reference ceiling

    // Word conversion modes
    typedef enum logic [1:0] {
        LSB_MODE_X1,
        LSB_MODE_X4,
        LSB_MODE_X7,
        LSB_MODE_X8
    } lsb_mode_t;

    // Bits per word for a mode, never above the multiplication limit
    function automatic logic [3:0] lsb_ratio(input lsb_mode_t m);
        logic [3:0] r;
        r = RATIO_X8;
        case (m)
            LSB_MODE_X1: r = RATIO_X1;
            LSB_MODE_X4: r = RATIO_X4;
            LSB_MODE_X7: r = RATIO_X7;
            default: r = RATIO_X8;
        endcase
        return (r > MAX_MULT) ? MAX_MULT : r;
    endfunction

endpackage

// ===== core/lsb_rx_lane.sv
// Purpose: One receive lane shift register and its word register.
// Assumes: Serial bit already synchronised; index kept by the bank.
// Notes:   Bit 0 of the word is the first bit received.
`timescale 1ns/100ps

module lsb_rx_lane
    import lsb_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic bit_en_i,                // One sample per bit
    input wire logic bit_i,                   // Synchronised serial bit
    input wire logic [IDX_W-1:0] idx_i,       // Position of this bit
    input wire logic word_end_i,              // Last bit of the word
    output logic [WORD_W-1:0] word_o          // Registered parallel word
);

    logic [WORD_W-1:0] shift_r;   // Bits collected so far
    logic [WORD_W-1:0] shift_nxt; // Collection with current bit placed

    // Place the current bit, clearing stale bits at word start
    always_comb
    begin
        shift_nxt = (idx_i == '0) ? '0 : shift_r;
        shift_nxt[idx_i] = bit_i;
    end

    // Dedicated shift register per lane
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            shift_r <= '0;
        else if (bit_en_i)
            shift_r <= shift_nxt;
    end

    // Word register handed to the fabric
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            word_o <= '0;
        else if (bit_en_i && word_end_i)
            word_o <= shift_nxt;
    end

endmodule

// ===== core/lsb_tx_lane.sv
// Purpose: One transmit lane shift register loaded from the fabric.
// Assumes: Load and shift timing kept by the bank.
// Notes:   Bit 0 of the word leaves first.
`timescale 1ns/100ps

module lsb_tx_lane
    import lsb_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic bit_en_i,                // One shift per bit
    input wire logic load_i,                  // First bit of a new word
    input wire logic [WORD_W-1:0] word_i,     // Parallel word to send
    output logic bit_o                        // Registered serial bit
);

    logic [WORD_W-1:0] shift_r; // Bits still to leave

    // Load a fresh word or move one bit along
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            shift_r <= '0;
        else if (bit_en_i && load_i)
            shift_r <= {1'b0, word_i[WORD_W-1:1]};
        else if (bit_en_i)
            shift_r <= {1'b0, shift_r[WORD_W-1:1]};
    end

    // Output flop changes on the same edge as the forwarded clock
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            bit_o <= 1'b0;
        else if (bit_en_i && load_i)
            bit_o <= word_i[0];
        else if (bit_en_i)
            bit_o <= shift_r[0];
    end

endmodule

// ===== verification/lsb_far_dev.sv
// Purpose: Far-side link device driving the bank's receive lanes.
// Assumes: Its bit clock stands low between bursts.
// Notes:   Released lanes show the inverse of their last bit.
`timescale 1ns/100ps

module lsb_far_dev
    import lsb_pkg::*;
(
    output logic link_clk_o,        // Forwarded bit clock
    output logic [LANES-1:0] lane_o // Serial lanes
);

    // ------------------------------------------------------------
    // Idle levels
    // ------------------------------------------------------------
    initial
    begin
        link_clk_o = 1'b0;
        lane_o = 16'h0000;
    end

    // ------------------------------------------------------------
    // Two-word burst, bit 0 first, data set on the falling edge
    // ------------------------------------------------------------
    // One bit per forwarded clock
    // One forwarded clock times every lane
    task automatic send2(input int r, input logic [BUS_W-1:0] w0,
                         input logic [BUS_W-1:0] w1);
        logic [BUS_W-1:0] w;
        #7;
        for (int n = 0; n < 2; n++)
        begin
            w = (n == 0) ? w0 : w1;
            for (int k = 0; k < r; k++)
            begin
                for (int l = 0; l < LANES; l++)
                    lane_o[l] = w[l*WORD_W+k];
                #100 link_clk_o = 1'b1;
                #100 link_clk_o = 1'b0;
            end
        end
        // Released lines must not keep the last value
        lane_o = ~lane_o;
    endtask

endmodule

// ===== verification/test_lsb_bank.sv
// Purpose: Self-checking bench for the serial lane bank.
// Assumes: Local transmit bit of 8 cycles; link period 200 ns.
// Notes:   Each scenario is one task that judges its own results.
`timescale 1ns/100ps

module test_lsb_bank
    import lsb_pkg::*;
;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic sys_clk_i, rst_n_i, tx_ref_sel_i, rx_link_clk_i;
    lsb_mode_t mode_sel_i;
    logic [LANES-1:0] rx_lane_i, tx_lane_o;
    logic [BUS_W-1:0] rx_data_o, tx_data_i;
    logic rx_word_valid_o, word_tick_o, tx_word_take_o, tx_fwd_clk_o;
    logic [3:0] ratio_o;
    int n_mismatch = 0; // Mismatch count
    int compares = 0;   // Comparison count
    int cyc = 0;        // Timeout counter

    lsb_bank dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .mode_sel_i(mode_sel_i), .tx_ref_sel_i(tx_ref_sel_i),
        .rx_link_clk_i(rx_link_clk_i), .rx_lane_i(rx_lane_i),
        .rx_data_o(rx_data_o), .rx_word_valid_o(rx_word_valid_o),
        .word_tick_o(word_tick_o), .tx_data_i(tx_data_i),
        .tx_word_take_o(tx_word_take_o), .tx_lane_o(tx_lane_o),
        .tx_fwd_clk_o(tx_fwd_clk_o), .ratio_o(ratio_o));

    lsb_far_dev far (.link_clk_o(rx_link_clk_i), .lane_o(rx_lane_i));

    // ------------------------------------------------------------
    // Clock and hang guard
    // ------------------------------------------------------------
    initial
    begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    always @(posedge sys_clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            results();
        end
    end

    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [BUS_W-1:0] seen,
                         input logic [BUS_W-1:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask

    // Test word, only the low r bits of each lane set
    function automatic logic [BUS_W-1:0] pat(input int r, input int s);
        logic [BUS_W-1:0] v;
        v = {BUS_W{1'b0}};
        for (int l = 0; l < LANES; l++)
            for (int k = 0; k < r; k++)
                v[l*WORD_W+k] = ((l * 7 + k * 3 + s) % 5) < 2;
        return v;
    endfunction

    // Bounded wait at falling edges for a flag
    task automatic wait_hi(ref logic f, input string what);
        int t;
        t = 0;
        @(negedge sys_clk_i);
        while (f !== 1'b1 && t < 200)
        begin
            @(negedge sys_clk_i);
            t++;
        end
        check(what, f, 1'b1);
    endtask

    task automatic results();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Reset: outputs quiet, widest ratio
    task automatic do_reset();
        @(posedge sys_clk_i);
        rst_n_i <= 1'b0;
        repeat (8) @(posedge sys_clk_i);
        check("rst_ratio", ratio_o, 4'h8);
        check("rst_valid", rx_word_valid_o, 1'b0);
        check("rst_lane", tx_lane_o, 16'h0000);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
    endtask

    // Two back-to-back received words in one mode
    task automatic rx_words(input lsb_mode_t m, input int r);
        logic [BUS_W-1:0] e [2];
        e[0] = pat(r, 1);
        e[1] = pat(r, 2);
        @(posedge sys_clk_i);
        mode_sel_i <= m;
        repeat (2) @(posedge sys_clk_i);
        check("ratio", ratio_o, r);
        fork
            far.send2(r, e[0], e[1]);
            for (int n = 0; n < 2; n++)
            begin
                wait_hi(rx_word_valid_o, "rx_valid");
                check("rx_data", rx_data_o, e[n]);
                check("rx_tick", word_tick_o, 1'b1);
                @(negedge sys_clk_i);
                check("rx_pulse", rx_word_valid_o, 1'b0);
            end
        join
    endtask

    // One transmitted word, bit by bit, with the forwarded clock
    task automatic tx_word(input lsb_mode_t m, input int r);
        logic [BUS_W-1:0] d;
        logic [LANES-1:0] e;
        d = pat(8, 3);
        @(posedge sys_clk_i);
        mode_sel_i <= m;
        tx_data_i <= d;
        // First take may open a word of the old mode
        wait_hi(tx_word_take_o, "tx_take");
        wait_hi(tx_word_take_o, "tx_take");
        for (int k = 0; k < r; k++)
        begin
            repeat ((k == 0) ? 3 : 8) @(negedge sys_clk_i);
            for (int l = 0; l < LANES; l++)
                e[l] = d[l*WORD_W+k];
            check("tx_lane", tx_lane_o, e);
            check("fwd", tx_fwd_clk_o, (r == 1) || (k < (r + 1) / 2));
        end
        repeat (4) @(negedge sys_clk_i);
        check("fwd_low", tx_fwd_clk_o, 1'b0);
        check("take_gap", tx_word_take_o, 1'b0);
        @(negedge sys_clk_i);
        check("take_due", tx_word_take_o, 1'b1);
    endtask

    // Transmit timing taken from the receive link clock
    task automatic linked();
        int n;
        n = 0;
        @(posedge sys_clk_i);
        tx_ref_sel_i <= 1'b1;
        fork
            rx_words(LSB_MODE_X4, 4);
            repeat (100) @(negedge sys_clk_i) n += (tx_word_take_o === 1'b1);
        join
        check("linked_take", n, 2);
        // Bypass: forwarded clock must fall with the link clock
        rx_words(LSB_MODE_X1, 1);
        repeat (8) @(negedge sys_clk_i);
        check("linked_fwd", tx_fwd_clk_o, 1'b0);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        rst_n_i = 1'b0;
        mode_sel_i = LSB_MODE_X8;
        tx_ref_sel_i = 1'b0;
        tx_data_i = {BUS_W{1'b0}};
        do_reset();
        rx_words(LSB_MODE_X8, 8);
        rx_words(LSB_MODE_X7, 7);
        rx_words(LSB_MODE_X4, 4);
        rx_words(LSB_MODE_X1, 1);
        tx_word(LSB_MODE_X8, 8);
        tx_word(LSB_MODE_X7, 7);
        tx_word(LSB_MODE_X4, 4);
        tx_word(LSB_MODE_X1, 1);
        do_reset();
        linked();
        results();
    end

endmodule
